// ---- rtc_flags_pkg.sv ----
// constants, field layouts and carrier types of the clock flags and alarm block
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package rtc_flags_pkg;
  // ----------------------------------------
  // bus and register map
  // ----------------------------------------
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = 17'h1FFF0;
  localparam logic [ADDR_W-1:0] ADDR_CENTURIES = 17'h1FFF1;
  localparam logic [ADDR_W-1:0] ADDR_ALM_SEC = 17'h1FFF2;
  localparam logic [ADDR_W-1:0] ADDR_ALM_MIN = 17'h1FFF3;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BIT_WDOG = 7;
  localparam int BIT_ALARM = 6;
  localparam int BIT_SUPPLY = 5;
  localparam int BIT_OSC = 4;
  localparam int BIT_CAL = 2;
  localparam int BIT_FREEZE = 1;
  localparam int BIT_CAPTURE = 0;
  localparam int BIT_MASK = 7;
  localparam int BCD_W = 7;
  localparam int CENT_W = 6;
  localparam logic [3:0] BCD_NINE = 4'h9;
  localparam logic [1:0] CENT_TENS_MAX = 2'h3;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [DATA_W-1:0] ALARM_RESET = 8'h00;
  localparam logic [CENT_W-1:0] CENT_RESET = 6'h00;
  localparam int N_ALARM = 2;
  localparam int ALM_SEC = 0;
  localparam int ALM_MIN = 1;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int OSC_START_MS = 5;
  localparam int SQW_HZ = 512;
  localparam int OSC_START_CYC = OSC_START_MS * (CLK_HZ / 1000);
  localparam int SQW_HALF_CYC = CLK_HZ / (2 * SQW_HZ);
  localparam int OSC_CNT_W = 17;
  localparam int SQW_CNT_W = 16;
  // ----------------------------------------
  // carrier of one completed bus access
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic rd_done;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bus_evt_t;
  typedef enum logic {osc_wait, osc_done} osc_state_t;
endpackage : rtc_flags_pkg

// ---- bus_port.sv ----
// end-of-cycle detection for the byte-wide asynchronous memory bus
`timescale 1ns/1ps
module bus_port
  import rtc_flags_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // memory bus pins
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  // decoded accesses
  output bus_evt_t evt,
  output logic rd_active
);
  logic wr_now;
  logic wr_prev;
  logic rd_prev;
  logic [ADDR_W-1:0] hold_addr;
  logic [DATA_W-1:0] hold_data;

  assign wr_now = ~ce_n & ~we_n;
  assign rd_active = ~ce_n & we_n & ~oe_n;

  // a write takes effect when the strobe ends, as on a real sram cycle
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wr_prev <= 1'b0;
      rd_prev <= 1'b0;
      hold_addr <= '0;
      hold_data <= '0;
    end else begin
      wr_prev <= wr_now;
      rd_prev <= rd_active;
      if (wr_now | rd_active) begin
        hold_addr <= addr;
      end
      if (wr_now) begin
        hold_data <= dq_in;
      end
    end
  end

  assign evt.wr = wr_prev & ~wr_now;
  assign evt.rd_done = rd_prev & ~rd_active;
  assign evt.addr = hold_addr;
  assign evt.data = hold_data;
endmodule : bus_port

// ---- sqw_divider.sv ----
// square wave divider for the calibration output
`timescale 1ns/1ps
module sqw_divider
  import rtc_flags_pkg::*;
#(
  parameter logic [SQW_CNT_W-1:0] HALF_CYCLES = SQW_HALF_CYC[SQW_CNT_W-1:0]
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // control and wave
  input wire logic run,
  output logic wave
);
  logic [SQW_CNT_W-1:0] count;
  logic half_done;

  assign half_done = (count == HALF_CYCLES - 1'b1);

  // held in phase zero while stopped so each enable starts a clean period
  always_ff @(posedge core_clk) begin
    if (!nrst || !run) begin
      count <= '0;
      wave <= 1'b0;
    end else if (half_done) begin
      count <= '0;
      wave <= ~wave;
    end else begin
      count <= count + 1'b1;
    end
  end
endmodule : sqw_divider

// ---- rtc_alarm_flags_control.sv ----
// flags, alarm match, centuries and interrupt pin logic of the clock block
`timescale 1ns/1ps
module rtc_alarm_flags_control
  import rtc_flags_pkg::*;
#(
  parameter logic [OSC_CNT_W-1:0] OSC_START_CYCLES = OSC_START_CYC[OSC_CNT_W-1:0],
  parameter logic [SQW_CNT_W-1:0] SQW_HALF_CYCLES = SQW_HALF_CYC[SQW_CNT_W-1:0]
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // memory bus pins
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  // running time from the timekeeping counters
  input wire logic time_tick,
  input wire logic [BCD_W-1:0] cur_seconds,
  input wire logic [BCD_W-1:0] cur_minutes,
  input wire logic upper_fields_match,
  input wire logic century_tick,
  // event sources
  input wire logic watchdog_expire,
  input wire logic supply_low,
  input wire logic osc_running,
  input wire logic osc_flag_retained,
  // interrupt control
  input wire logic alarm_irq_enable,
  input wire logic watchdog_irq_enable,
  input wire logic int_active_high,
  // timekeeping control
  output logic time_freeze,
  output logic time_load,
  output logic time_capture,
  output logic [CENT_W-1:0] centuries_now,
  output logic osc_dead_flag,
  // interrupt pin
  output logic int_out,
  output logic int_oe
);
  // ------------------------------------------------------------------
  // bus access detection
  // ------------------------------------------------------------------
  bus_evt_t evt;
  logic rd_active;

  bus_port bus_port_i (
    .core_clk (core_clk),
    .nrst (nrst),
    .addr (addr),
    .dq_in (dq_in),
    .ce_n (ce_n),
    .we_n (we_n),
    .oe_n (oe_n),
    .evt (evt),
    .rd_active (rd_active)
  );

  // ------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------
  wire wr_flags = evt.wr & (evt.addr == ADDR_FLAGS);
  wire wr_cent = evt.wr & (evt.addr == ADDR_CENTURIES);
  wire rd_flags_done = evt.rd_done & (evt.addr == ADDR_FLAGS);
  wire hit_flags = (addr == ADDR_FLAGS);
  wire hit_cent = (addr == ADDR_CENTURIES);
  wire hit_sec = (addr == ADDR_ALM_SEC);
  wire hit_min = (addr == ADDR_ALM_MIN);
  wire hit_any = hit_flags | hit_cent | hit_sec | hit_min;

  // ------------------------------------------------------------------
  // alarm registers and field comparators
  // ------------------------------------------------------------------
  logic [DATA_W-1:0] alarm_reg [N_ALARM];
  logic [N_ALARM-1:0] field_hit;
  logic [BCD_W-1:0] cur_field [N_ALARM];
  logic [ADDR_W-1:0] alarm_addr [N_ALARM];

  assign cur_field[ALM_SEC] = cur_seconds;
  assign cur_field[ALM_MIN] = cur_minutes;
  assign alarm_addr[ALM_SEC] = ADDR_ALM_SEC;
  assign alarm_addr[ALM_MIN] = ADDR_ALM_MIN;

  genvar gi;
  generate
    for (gi = 0; gi < N_ALARM; gi++) begin : g_alarm
      wire wr_this = evt.wr & (evt.addr == alarm_addr[gi]);

      // whole byte is stored: bit 7 mask, bits 6-4 tens, bits 3-0 units
      always_ff @(posedge core_clk) begin
        if (!nrst) begin
          alarm_reg[gi] <= ALARM_RESET;
        end else if (wr_this) begin
          alarm_reg[gi] <= evt.data;
        end
      end

      // a set mask bit removes the field from the match
      assign field_hit[gi] = alarm_reg[gi][BIT_MASK]
                             | (alarm_reg[gi][BCD_W-1:0] == cur_field[gi]);
    end
  endgenerate

  // compared once per counter update so a match raises the flag only once
  wire alarm_event = time_tick & (&field_hit) & upper_fields_match;

  // ------------------------------------------------------------------
  // control bits of the flags register
  // ------------------------------------------------------------------
  logic cal_mode;
  logic freeze;
  logic capture;
  logic freeze_prev;
  logic capture_prev;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cal_mode <= 1'b0;
      freeze <= 1'b0;
      capture <= 1'b0;
    end else if (wr_flags) begin
      cal_mode <= evt.data[BIT_CAL];
      freeze <= evt.data[BIT_FREEZE];
      capture <= evt.data[BIT_CAPTURE];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      freeze_prev <= 1'b0;
      capture_prev <= 1'b0;
    end else begin
      freeze_prev <= freeze;
      capture_prev <= capture;
    end
  end

  // only the rising edge of the capture bit snapshots; holding it high
  // keeps the old image, so software must lower it before the next one
  wire capture_edge = capture & ~capture_prev;
  wire load_edge = freeze_prev & ~freeze;

  assign time_freeze = freeze;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      time_load <= 1'b0;
      time_capture <= 1'b0;
    end else begin
      time_load <= load_edge;
      time_capture <= capture_edge;
    end
  end

  // ------------------------------------------------------------------
  // sticky event flags
  // ------------------------------------------------------------------
  logic wdog_flag;
  logic alarm_flag;
  logic supply_flag;
  logic supply_prev;

  wire supply_event = supply_low & ~supply_prev;

  // an event in the cycle of the clearing read wins, so none is lost
  wire next_wdog_flag = watchdog_expire | (wdog_flag & ~rd_flags_done);
  wire next_alarm_flag = alarm_event | (alarm_flag & ~rd_flags_done);
  wire next_supply_flag = supply_event | (supply_flag & ~rd_flags_done);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wdog_flag <= 1'b0;
      alarm_flag <= 1'b0;
      supply_flag <= 1'b0;
      supply_prev <= 1'b0;
    end else begin
      wdog_flag <= next_wdog_flag;
      alarm_flag <= next_alarm_flag;
      supply_flag <= next_supply_flag;
      supply_prev <= supply_low;
    end
  end

  // ------------------------------------------------------------------
  // oscillator start check
  // ------------------------------------------------------------------
  osc_state_t osc_state;
  logic [OSC_CNT_W-1:0] osc_count;
  logic osc_flag;

  wire osc_window_end = (osc_state == osc_wait) && (osc_count == OSC_START_CYCLES - 1'b1);
  wire osc_set = osc_window_end & ~osc_running;
  wire osc_clear = wr_flags & ~evt.data[BIT_OSC];

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      osc_state <= osc_wait;
      osc_count <= '0;
    end else begin
      case (osc_state)
        osc_wait: begin
          osc_count <= osc_count + 1'b1;
          if (osc_window_end) begin
            osc_state <= osc_done;
          end
        end
        osc_done: begin
          osc_count <= osc_count;
        end
        default: begin
          osc_state <= osc_done;
        end
      endcase
    end
  end

  // reset reloads the value kept in the backup domain instead of losing it;
  // the block itself never clears the flag, only a software write of 0 does
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      osc_flag <= osc_flag_retained;
    end else if (osc_set) begin
      osc_flag <= 1'b1;
    end else if (osc_clear) begin
      osc_flag <= 1'b0;
    end
  end

  assign osc_dead_flag = osc_flag;

  // ------------------------------------------------------------------
  // centuries counter with freeze, load and capture
  // ------------------------------------------------------------------
  logic [CENT_W-1:0] cent_run;
  logic [CENT_W-1:0] cent_written;
  logic [CENT_W-1:0] cent_hold;

  wire [3:0] cent_units = cent_run[3:0];
  wire [1:0] cent_tens = cent_run[CENT_W-1:4];
  wire units_wrap = (cent_units == BCD_NINE);
  wire [3:0] next_units = units_wrap ? 4'h0 : cent_units + 4'h1;
  wire [1:0] next_tens = !units_wrap ? cent_tens
                         : (cent_tens == CENT_TENS_MAX) ? 2'h0 : cent_tens + 2'h1;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cent_written <= CENT_RESET;
    end else if (wr_cent) begin
      cent_written <= evt.data[CENT_W-1:0];
    end
  end

  // counting stops while frozen; leaving the freeze loads the written value
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cent_run <= CENT_RESET;
    end else if (load_edge) begin
      cent_run <= cent_written;
    end else if (century_tick && !freeze) begin
      cent_run <= {next_tens, next_units};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cent_hold <= CENT_RESET;
    end else if (capture_edge) begin
      cent_hold <= cent_run;
    end
  end

  assign centuries_now = cent_run;

  // ------------------------------------------------------------------
  // read data
  // ------------------------------------------------------------------
  // a frozen counter shows what software wrote, a captured one the image
  wire [CENT_W-1:0] cent_view = freeze ? cent_written
                              : capture ? cent_hold
                              : cent_run;
  wire [DATA_W-1:0] flags_view = {wdog_flag,
                                  alarm_flag,
                                  supply_flag,
                                  osc_flag,
                                  1'b0,
                                  cal_mode,
                                  freeze,
                                  capture};
  wire [DATA_W-1:0] rd_mux = hit_flags ? flags_view
                           : hit_cent ? {2'b00, cent_view}
                           : hit_sec ? alarm_reg[ALM_SEC]
                           : hit_min ? alarm_reg[ALM_MIN]
                           : 8'h00;

  // read data is registered, so it trails the address by one cycle
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      dq_out <= 8'h00;
      dq_oe <= 1'b0;
    end else begin
      dq_out <= rd_mux;
      dq_oe <= rd_active & hit_any;
    end
  end

  // ------------------------------------------------------------------
  // interrupt pin
  // ------------------------------------------------------------------
  logic sqw;

  sqw_divider #(
    .HALF_CYCLES (SQW_HALF_CYCLES)
  ) sqw_divider_i (
    .core_clk (core_clk),
    .nrst (nrst),
    .run (cal_mode),
    .wave (sqw)
  );

  // the pin follows the enabled alarm and watchdog flags, so it releases when the flags read clears
  wire irq_level = (alarm_flag & alarm_irq_enable)
                 | (wdog_flag & watchdog_irq_enable);
  // calibration mode overrides the interrupt sources entirely
  wire pin_level = cal_mode ? sqw : irq_level;

  // in reset the pin is released, so an open-drain line rests at its pull-up
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      int_out <= 1'b0;
      int_oe <= 1'b0;
    end else if (int_active_high) begin
      int_out <= pin_level;
      int_oe <= 1'b1;
    end else begin
      int_out <= 1'b0;
      int_oe <= pin_level;
    end
  end
endmodule : rtc_alarm_flags_control

// ---- rtc_alarm_flags_monitor.sv ----
// assertion checker for the clock flags and alarm block
`timescale 1ns/1ps
module rtc_alarm_flags_monitor
  import rtc_flags_pkg::*;
#(
  parameter logic [OSC_CNT_W-1:0] OSC_START_CYCLES = OSC_START_CYC[OSC_CNT_W-1:0]
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // memory bus
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic dq_oe,
  // timekeeping and status
  input wire logic time_freeze,
  input wire logic time_load,
  input wire logic time_capture,
  input wire logic osc_running,
  input wire logic osc_dead_flag,
  // interrupt pin
  input wire logic alarm_irq_enable,
  input wire logic watchdog_irq_enable,
  input wire logic int_active_high,
  input wire logic int_out,
  input wire logic int_oe
);
  // ----------------------------------------
  // shadow of the last completed write
  // ----------------------------------------
  logic wr_ph;
  logic [ADDR_W-1:0] wr_a;
  logic [DATA_W-1:0] wr_d;
  logic cal_sh;
  logic cap_sh;
  logic [OSC_CNT_W-1:0] up_cnt;
  wire wr_end = wr_ph && (ce_n || we_n);
  wire flags_wr = wr_end && (wr_a == ADDR_FLAGS);
  wire rd_act = !ce_n && we_n && !oe_n;
  wire mapped = addr[ADDR_W-1:2] == ADDR_FLAGS[ADDR_W-1:2];
  // cal shadow lets the irq checks step aside while the square wave owns the pin
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wr_ph <= 1'b0;
      cal_sh <= 1'b0;
      cap_sh <= 1'b0;
      up_cnt <= '0;
    end else begin
      wr_ph <= !ce_n && !we_n;
      if (!ce_n && !we_n) begin
        wr_a <= addr;
        wr_d <= dq_in;
      end
      if (flags_wr) begin
        cal_sh <= wr_d[BIT_CAL];
        cap_sh <= wr_d[BIT_CAPTURE];
      end
      if (up_cnt != OSC_START_CYCLES + 2) up_cnt <= up_cnt + 1'b1;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_osc_start_flag: assert property (
    up_cnt == OSC_START_CYCLES + 1 && !osc_running |-> osc_dead_flag)
    else $error("oscillator flag not set after start window");
  a_osc_flag_kept: assert property (
    $fell(osc_dead_flag) |-> wr_a == ADDR_FLAGS && !wr_d[BIT_OSC])
    else $error("oscillator flag cleared without a host write");
  a_read_drive: assert property (
    rd_act && mapped |=> dq_oe) else $error("mapped read not driven");
  a_unmapped_quiet: assert property (
    !(rd_act && mapped) |=> !dq_oe) else $error("data bus driven outside a mapped read");
  a_freeze_follow: assert property (
    flags_wr |-> ##[1:3] (time_freeze == wr_d[BIT_FREEZE]))
    else $error("freeze output does not follow written bit");
  a_load_after_thaw: assert property (
    $fell(time_freeze) |-> ##[1:3] time_load) else $error("no load after freeze cleared");
  a_load_single: assert property (
    time_load |-> !time_freeze ##1 !time_load) else $error("load pulse malformed");
  a_capture_rise: assert property (
    $rose(cap_sh) |-> ##[1:4] time_capture) else $error("no capture after capture bit rose");
  a_capture_single: assert property (
    time_capture |=> !time_capture) else $error("capture pulse longer than one cycle");
  a_irq_quiet: assert property (
    (!alarm_irq_enable && !watchdog_irq_enable && !cal_sh && $stable(int_active_high))[*3]
    |-> (int_active_high ? !int_out : !int_oe)) else $error("interrupt pin active while disabled");
  a_pp_drive: assert property (
    int_active_high && $past(int_active_high) && $past(nrst) |-> int_oe)
    else $error("push-pull pin not driven");
  a_od_low: assert property (
    !int_active_high && !$past(int_active_high) |-> !int_out)
    else $error("open-drain pin driven high");
endmodule : rtc_alarm_flags_monitor

bind rtc_alarm_flags_control rtc_alarm_flags_monitor #(.OSC_START_CYCLES(OSC_START_CYCLES))
  rtc_alarm_flags_monitor_i (.core_clk(core_clk), .nrst(nrst), .addr(addr), .dq_in(dq_in),
  .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .dq_oe(dq_oe), .time_freeze(time_freeze),
  .time_load(time_load), .time_capture(time_capture), .osc_running(osc_running),
  .osc_dead_flag(osc_dead_flag), .alarm_irq_enable(alarm_irq_enable),
  .watchdog_irq_enable(watchdog_irq_enable), .int_active_high(int_active_high),
  .int_out(int_out), .int_oe(int_oe));

// ---- host_bus_model.sv ----
// host processor model driving the asynchronous memory bus
`timescale 1ns/1ps
module host_bus_model
  import rtc_flags_pkg::*;
(
  // clock
  input wire logic core_clk,
  // memory bus pins
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] dq_in,
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic dq_oe
);
  initial begin
    addr = '0;
    dq_in = '0;
    ce_n = 1'b1;
    we_n = 1'b1;
    oe_n = 1'b1;
  end
  // released lines are inverted so a stale value never looks valid
  task automatic release_bus();
    ce_n = 1'b1;
    we_n = 1'b1;
    oe_n = 1'b1;
    addr = ~addr;
    dq_in = ~dq_in;
  endtask : release_bus
  // reserved bits always go out as 0; an idle cycle follows every access
  task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    #1;
    addr = a;
    dq_in = d & (a == ADDR_FLAGS ? 8'hF7 : a == ADDR_CENTURIES ? 8'h3F : 8'hFF);
    ce_n = 1'b0;
    we_n = 1'b0;
    @(posedge core_clk);
    #1;
    release_bus();
    @(posedge core_clk);
    #1;
  endtask : bus_write
  task automatic bus_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                          output logic oe);
    @(posedge core_clk);
    #1;
    addr = a;
    ce_n = 1'b0;
    oe_n = 1'b0;
    @(posedge core_clk);
    @(posedge core_clk);
    d = dq_out;
    oe = dq_oe;
    #1;
    release_bus();
    @(posedge core_clk);
    #1;
  endtask : bus_read
endmodule : host_bus_model

// ---- rtc_alarm_flags_control_tb_top.sv ----
// testbench of the clock flags and alarm block
`timescale 1ns/1ps
module rtc_alarm_flags_control_tb_top;
  import rtc_flags_pkg::*;
  localparam logic [OSC_CNT_W-1:0] OSC_CYC = 17'h00032;
  localparam logic [SQW_CNT_W-1:0] HALF_CYC = 16'h0004;
  logic core_clk, nrst, time_tick, century_tick, upper_fields_match, watchdog_expire;
  logic supply_low, osc_running, osc_flag_retained, alarm_irq_enable, watchdog_irq_enable;
  logic int_active_high, ce_n, we_n, oe_n, dq_oe, time_freeze, time_load, time_capture;
  logic osc_dead_flag, int_out, int_oe;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dq_in, dq_out;
  logic [BCD_W-1:0] cur_seconds, cur_minutes;
  logic [CENT_W-1:0] centuries_now;
  int errors, checks, caps, n;
  rtc_alarm_flags_control #(.OSC_START_CYCLES(OSC_CYC), .SQW_HALF_CYCLES(HALF_CYC))
    rtc_alarm_flags_control_i (.core_clk(core_clk), .nrst(nrst), .addr(addr), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
    .time_tick(time_tick), .cur_seconds(cur_seconds), .cur_minutes(cur_minutes),
    .upper_fields_match(upper_fields_match), .century_tick(century_tick),
    .watchdog_expire(watchdog_expire), .supply_low(supply_low), .osc_running(osc_running),
    .osc_flag_retained(osc_flag_retained), .alarm_irq_enable(alarm_irq_enable),
    .watchdog_irq_enable(watchdog_irq_enable), .int_active_high(int_active_high),
    .time_freeze(time_freeze), .time_load(time_load), .time_capture(time_capture),
    .centuries_now(centuries_now), .osc_dead_flag(osc_dead_flag), .int_out(int_out),
    .int_oe(int_oe));
  host_bus_model host_bus_model_i (.core_clk(core_clk), .addr(addr), .dq_in(dq_in),
    .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .dq_out(dq_out), .dq_oe(dq_oe));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (time_capture === 1'b1) caps++;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_of_test();
    if (errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask : chk1
  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    host_bus_model_i.bus_write(a, d);
  endtask : wr
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic oe;
    host_bus_model_i.bus_read(a, d, oe);
    chk1(oe, 1'b1);
    chk8(d, exp);
  endtask : rd_chk
  task automatic tick(input logic [BCD_W-1:0] s, input logic [BCD_W-1:0] m);
    cur_seconds = s;
    cur_minutes = m;
    time_tick = 1'b1;
    step(1);
    time_tick = 1'b0;
    step(2);
  endtask : tick
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_osc();
    logic [7:0] d;
    logic oe;
    step(OSC_CYC + 5);
    chk1(osc_dead_flag, 1'b1);
    rd_chk(ADDR_FLAGS, 8'h10);
    rd_chk(ADDR_FLAGS, 8'h10);
    wr(ADDR_FLAGS, 8'h00);
    step(2);
    chk1(osc_dead_flag, 1'b0);
    osc_running = 1'b1;
    osc_flag_retained = 1'b1;
    nrst = 1'b0;
    step(2);
    nrst = 1'b1;
    step(OSC_CYC + 5);
    chk1(osc_dead_flag, 1'b1);
    rd_chk(ADDR_FLAGS, 8'h10);
    wr(ADDR_FLAGS, 8'h00);
    osc_flag_retained = 1'b0;
    rd_chk(ADDR_ALM_SEC, 8'h00);
    rd_chk(ADDR_ALM_MIN, 8'h00);
    wr(ADDR_ALM_SEC, 8'hD9);
    rd_chk(ADDR_ALM_SEC, 8'hD9);
    wr(ADDR_ALM_MIN, 8'hA7);
    rd_chk(ADDR_ALM_MIN, 8'hA7);
    host_bus_model_i.bus_read(17'h1FFF4, d, oe);
    chk1(oe, 1'b0);
  endtask : t_osc
  task automatic t_time();
    wr(ADDR_FLAGS, 8'h02);
    step(1);
    chk1(time_freeze, 1'b1);
    wr(ADDR_CENTURIES, 8'h39);
    rd_chk(ADDR_CENTURIES, 8'h39);
    wr(ADDR_FLAGS, 8'h00);
    n = 0;
    repeat (5) begin
      if (time_load === 1'b1) n++;
      step(1);
    end
    chk8(n[7:0], 8'h01);
    chk8({2'b00, centuries_now}, 8'h39);
    century_tick = 1'b1;
    step(1);
    century_tick = 1'b0;
    rd_chk(ADDR_CENTURIES, 8'h00);
  endtask : t_time
  task automatic t_capture();
    caps = 0;
    wr(ADDR_FLAGS, 8'h01);
    step(4);
    chk8(caps[7:0], 8'h01);
    century_tick = 1'b1;
    step(1);
    century_tick = 1'b0;
    rd_chk(ADDR_CENTURIES, 8'h00);
    wr(ADDR_FLAGS, 8'h01);
    step(4);
    chk8(caps[7:0], 8'h01);
    wr(ADDR_FLAGS, 8'h00);
    wr(ADDR_FLAGS, 8'h01);
    step(4);
    chk8(caps[7:0], 8'h02);
    rd_chk(ADDR_CENTURIES, 8'h01);
    wr(ADDR_FLAGS, 8'h00);
  endtask : t_capture
  task automatic t_alarm();
    alarm_irq_enable = 1'b1;
    wr(ADDR_ALM_SEC, 8'h30);
    wr(ADDR_ALM_MIN, 8'h80);
    tick(7'h30, 7'h12);
    chk1(int_oe, 1'b1);
    chk1(int_out, 1'b0);
    rd_chk(ADDR_FLAGS, 8'h40);
    step(2);
    chk1(int_oe, 1'b0);
    tick(7'h31, 7'h12);
    rd_chk(ADDR_FLAGS, 8'h00);
    wr(ADDR_ALM_MIN, 8'h13);
    tick(7'h30, 7'h12);
    rd_chk(ADDR_FLAGS, 8'h00);
    wr(ADDR_ALM_SEC, 8'h80);
    tick(7'h05, 7'h13);
    rd_chk(ADDR_FLAGS, 8'h40);
    alarm_irq_enable = 1'b0;
  endtask : t_alarm
  task automatic t_events();
    int_active_high = 1'b1;
    watchdog_irq_enable = 1'b1;
    watchdog_expire = 1'b1;
    step(1);
    watchdog_expire = 1'b0;
    step(2);
    chk1(int_out, 1'b1);
    chk1(int_oe, 1'b1);
    supply_low = 1'b1;
    step(2);
    rd_chk(ADDR_FLAGS, 8'hA0);
    step(2);
    chk1(int_out, 1'b0);
    rd_chk(ADDR_FLAGS, 8'h00);
    supply_low = 1'b0;
    watchdog_irq_enable = 1'b0;
  endtask : t_events
  task automatic t_cal();
    wr(ADDR_FLAGS, 8'h04);
    rd_chk(ADDR_FLAGS, 8'h04);
    n = 0;
    while (int_out !== 1'b1 && n < 50) begin
      step(1);
      n++;
    end
    n = 0;
    while (int_out === 1'b1 && n < 50) begin
      step(1);
      n++;
    end
    chk8(n[7:0], HALF_CYC[7:0]);
    wr(ADDR_FLAGS, 8'h00);
    step(3);
    chk1(int_out, 1'b0);
    wr(ADDR_FLAGS, 8'h04);
    nrst = 1'b0;
    step(2);
    nrst = 1'b1;
    rd_chk(ADDR_FLAGS, 8'h00);
  endtask : t_cal
  initial begin
    {nrst, time_tick, century_tick, upper_fields_match, watchdog_expire} = '0;
    {supply_low, osc_running, osc_flag_retained, alarm_irq_enable} = '0;
    {watchdog_irq_enable, int_active_high, cur_seconds, cur_minutes} = '0;
    errors = 0;
    checks = 0;
    caps = 0;
    upper_fields_match = 1'b1;
    step(16);
    nrst = 1'b1;
    t_osc();
    t_time();
    t_capture();
    t_alarm();
    t_events();
    t_cal();
    end_of_test();
  end
  initial begin
    #200000;
    errors++;
    end_of_test();
  end
endmodule : rtc_alarm_flags_control_tb_top
